// ### data_eeprom_access.sv
// register front end and control of the 128 byte nonvolatile data array
// assumes one AHB-Lite master; reset_n is the power-on reset, pin and
// watchdog resets arrive as warm reset requests
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_access_map.svh"
module data_eeprom_access #(
    parameter logic [22:0] PWRUP_CYCLES = 23'(`NVM_PWRUP_CYCLES),
    parameter logic [15:0] PROG_CYCLES  = 16'(`NVM_PROG_CYCLES)
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // warm reset sources
    input  wire logic        pin_reset_n,
    input  wire logic        wdt_reset,
    // configuration fuse
    input  wire logic        data_lock_fuse,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // status
    output logic             program_busy,
    output logic             program_done_flag,
    output logic             programmer_access_en
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic pinrst_meta_reg;
    logic pinrst_sync_reg;
    logic fuse_meta_reg;
    logic fuse_sync_reg;
    logic warm_reset;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinrst_meta_reg <= 1'b1;
            pinrst_sync_reg <= 1'b1;
            fuse_meta_reg   <= 1'b1;
            fuse_sync_reg   <= 1'b1;
        end else if (clk_en) begin
            pinrst_meta_reg <= pin_reset_n;
            pinrst_sync_reg <= pinrst_meta_reg;
            fuse_meta_reg   <= data_lock_fuse;
            fuse_sync_reg   <= fuse_meta_reg;
        end
    end

    assign warm_reset = !pinrst_sync_reg || wdt_reset;

    // ************************************************************
    // bus phases
    // ************************************************************
    // one wait state so that read data leaves a flip-flop
    logic        wait_reg;
    logic        wait_next;
    logic        wr_reg;
    logic        wr_next;
    logic        mapped_reg;
    logic        mapped_next;
    logic [7:0]  idx_reg;
    logic [7:0]  idx_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        take;
    logic        commit;
    logic        wr_commit;
    logic [7:0]  wbyte;
    logic [7:0]  rd_value;

    assign take      = hsel && htrans[1] && hready;
    assign commit    = wait_reg;
    assign wr_commit = commit && wr_reg && mapped_reg;
    assign wbyte     = hwdata[7:0];

    always_comb begin
        wait_next   = 1'b0;
        wr_next     = wr_reg;
        mapped_next = mapped_reg;
        idx_next    = idx_reg;
        rdata_next  = rdata_reg;
        if (commit) begin
            rdata_next = (!wr_reg && mapped_reg) ? {24'h000000, rd_value} : 32'h00000000;
        end
        if (take && !wait_reg) begin
            wait_next   = 1'b1;
            wr_next     = hwrite;
            mapped_next = (haddr[31:10] == 22'h000000);
            idx_next    = haddr[9:2];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg   <= 1'b0;
            wr_reg     <= 1'b0;
            mapped_reg <= 1'b0;
            idx_reg    <= 8'h00;
            rdata_reg  <= 32'h00000000;
        end else if (clk_en) begin
            wait_reg   <= wait_next;
            wr_reg     <= wr_next;
            mapped_reg <= mapped_next;
            idx_reg    <= idx_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign hreadyout = !wait_reg;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    // ************************************************************
    // register decode
    // ************************************************************
    logic wr_flag;
    logic wr_byte;
    logic wr_index;
    logic wr_control;
    logic wr_key;

    assign wr_flag    = wr_commit && (idx_reg == `NVM_IDX_FLAG);
    assign wr_byte    = wr_commit && (idx_reg == `NVM_IDX_BYTE);
    assign wr_index   = wr_commit && (idx_reg == `NVM_IDX_INDEX);
    assign wr_control = wr_commit && (idx_reg == `NVM_IDX_CONTROL);
    assign wr_key     = wr_commit && (idx_reg == `NVM_IDX_KEY);

    // ************************************************************
    // unlock detector
    // ************************************************************
    nvm_access_pkg::key_state_e key_state_reg;
    nvm_access_pkg::key_state_e key_state_next;
    logic [2:0] gap_reg;
    logic [2:0] gap_next;
    logic       gap_ok;
    logic       unlocked;

    assign gap_ok   = (gap_reg == 3'(`NVM_UNLOCK_GAP_CYC - 1));
    assign unlocked = (key_state_reg == nvm_access_pkg::KEY_SECOND) && gap_ok;

    always_comb begin
        key_state_next = key_state_reg;
        gap_next       = (gap_reg == 3'h7) ? gap_reg : gap_reg + 3'h1;
        if (commit) begin
            gap_next = 3'h0;
            case (key_state_reg)
                nvm_access_pkg::KEY_IDLE: begin
                    key_state_next = nvm_access_pkg::KEY_IDLE;
                end
                nvm_access_pkg::KEY_FIRST: begin
                    if (wr_key && wbyte == `NVM_KEY_SECOND && gap_ok) begin
                        key_state_next = nvm_access_pkg::KEY_SECOND;
                    end else begin
                        key_state_next = nvm_access_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    key_state_next = nvm_access_pkg::KEY_IDLE;
                end
            endcase
            if (wr_key && wbyte == `NVM_KEY_FIRST) begin
                key_state_next = nvm_access_pkg::KEY_FIRST;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_state_reg <= nvm_access_pkg::KEY_IDLE;
            gap_reg       <= 3'h0;
        end else if (clk_en) begin
            if (warm_reset) begin
                key_state_reg <= nvm_access_pkg::KEY_IDLE;
                gap_reg       <= 3'h0;
            end else begin
                key_state_reg <= key_state_next;
                gap_reg       <= gap_next;
            end
        end
    end

    // ************************************************************
    // power-up timer
    // ************************************************************
    logic [22:0] pwrup_reg;
    logic [22:0] pwrup_next;
    logic        pwrup_busy;

    always_comb begin
        pwrup_next = (pwrup_reg != 23'h000000) ? pwrup_reg - 23'h000001 : pwrup_reg;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pwrup_reg <= PWRUP_CYCLES;
        end else if (clk_en) begin
            pwrup_reg <= pwrup_next;
        end
    end

    assign pwrup_busy = (pwrup_reg != 23'h000000);

    // ************************************************************
    // program cycle control
    // ************************************************************
    nvm_access_pkg::prog_state_e prog_state_reg;
    nvm_access_pkg::prog_state_e prog_state_next;
    logic       arm_reg;
    logic       arm_next;
    logic       prog_start;
    logic       timer_done;
    logic [6:0] tgt_addr_reg;
    logic [6:0] tgt_addr_next;
    logic [7:0] tgt_data_reg;
    logic [7:0] tgt_data_next;
    logic [7:0] index_reg;
    logic [7:0] byte_reg;

    // start only on a written one
    assign prog_start = wr_control && wbyte[`NVM_BIT_PROGRAM] && arm_reg && unlocked
                        && !pwrup_busy && (prog_state_reg == nvm_access_pkg::PROG_IDLE);

    always_comb begin
        prog_state_next = prog_state_reg;
        tgt_addr_next   = tgt_addr_reg;
        tgt_data_next   = tgt_data_reg;
        case (prog_state_reg)
            nvm_access_pkg::PROG_IDLE: begin
                if (prog_start) begin
                    prog_state_next = nvm_access_pkg::PROG_BUSY;
                    tgt_addr_next   = index_reg[`NVM_ADDR_BITS-1:0];
                    tgt_data_next   = byte_reg;
                end
            end
            nvm_access_pkg::PROG_BUSY: begin
                if (timer_done) begin
                    prog_state_next = nvm_access_pkg::PROG_IDLE;
                end
            end
            default: begin
                prog_state_next = nvm_access_pkg::PROG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prog_state_reg <= nvm_access_pkg::PROG_IDLE;
            tgt_addr_reg   <= 7'h00;
            tgt_data_reg   <= 8'h00;
        end else if (clk_en) begin
            if (warm_reset) begin
                prog_state_reg <= nvm_access_pkg::PROG_IDLE;
            end else begin
                prog_state_reg <= prog_state_next;
            end
            tgt_addr_reg <= tgt_addr_next;
            tgt_data_reg <= tgt_data_next;
        end
    end

    prog_cycle_timer u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .abort   (warm_reset),
        .start   (prog_start && !warm_reset),
        .length  (PROG_CYCLES),
        .busy    (),
        .done    (timer_done)
    );

    assign program_busy = (prog_state_reg == nvm_access_pkg::PROG_BUSY);

    // ************************************************************
    // data array
    // ************************************************************
    logic [7:0] mem [0:127];
    logic       mem_write;

    // cut cycles leave the location untouched
    assign mem_write = timer_done && program_busy && !warm_reset;

    always_ff @(posedge clk_sys) begin
        if (clk_en && mem_write) begin
            mem[tgt_addr_reg] <= tgt_data_reg;
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    logic [7:0] index_next;
    logic [7:0] byte_next;
    logic       fetch_reg;
    logic       fetch_next;
    logic       abort_reg;
    logic       abort_next;
    logic       done_reg;
    logic       done_next;

    always_comb begin
        index_next = index_reg;
        byte_next  = byte_reg;
        fetch_next = 1'b0;
        arm_next   = arm_reg;
        abort_next = abort_reg;
        done_next  = done_reg;
        if (wr_index) begin
            index_next = wbyte;
        end
        if (wr_byte) begin
            byte_next = wbyte;
        end
        if (fetch_reg) begin
            byte_next = mem[index_reg[`NVM_ADDR_BITS-1:0]];
        end
        if (wr_control) begin
            fetch_next = wbyte[`NVM_BIT_FETCH];
            arm_next   = wbyte[`NVM_BIT_ARM];
            abort_next = wbyte[`NVM_BIT_ABORT];
        end
        if (wr_flag) begin
            done_next = wbyte[`NVM_BIT_DONE];
        end
        if (mem_write) begin
            done_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            index_reg <= `NVM_RST_INDEX;
            byte_reg  <= `NVM_RST_BYTE;
            fetch_reg <= 1'b0;
            arm_reg   <= 1'b0;
            abort_reg <= `NVM_RST_ABORT;
            done_reg  <= `NVM_RST_FLAG;
        end else if (clk_en) begin
            if (warm_reset) begin
                index_reg <= `NVM_RST_INDEX;
                byte_reg  <= `NVM_RST_BYTE;
                fetch_reg <= 1'b0;
                arm_reg   <= 1'b0;
                abort_reg <= abort_reg || program_busy;
                done_reg  <= `NVM_RST_FLAG;
            end else begin
                index_reg <= index_next;
                byte_reg  <= byte_next;
                fetch_reg <= fetch_next;
                arm_reg   <= arm_next;
                abort_reg <= abort_next;
                done_reg  <= done_next;
            end
        end
    end

    assign program_done_flag = done_reg;

    // fuse at zero locks out programmer
    assign programmer_access_en = fuse_sync_reg;

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        rd_value = 8'h00;
        case (idx_reg)
            `NVM_IDX_FLAG: begin
                rd_value = {done_reg, 7'h00};
            end
            `NVM_IDX_BYTE: begin
                rd_value = byte_reg;
            end
            `NVM_IDX_INDEX: begin
                rd_value = index_reg;
            end
            `NVM_IDX_CONTROL: begin
                rd_value = {4'h0, abort_reg, arm_reg, program_busy, fetch_reg};
            end
            `NVM_IDX_KEY: begin
                rd_value = 8'h00;
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### nvm_access_map.svh
// constants for the data array access block: register indices, fields,
// key values, reset values and timing counts
// assumes a 100 MHz core clock and word-aligned register slots on AHB-Lite
`ifndef NVM_ACCESS_MAP_SVH
`define NVM_ACCESS_MAP_SVH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define NVM_IDX_FLAG      8'h0C
`define NVM_IDX_BYTE      8'h9A
`define NVM_IDX_INDEX     8'h9B
`define NVM_IDX_CONTROL   8'h9C
`define NVM_IDX_KEY       8'h9D

// ************************************************************
// field positions
// ************************************************************
`define NVM_BIT_FETCH     0
`define NVM_BIT_PROGRAM   1
`define NVM_BIT_ARM       2
`define NVM_BIT_ABORT     3
`define NVM_BIT_DONE      7
`define NVM_ADDR_BITS     7

// ************************************************************
// reset values and keys
// ************************************************************
`define NVM_RST_BYTE      8'h00
`define NVM_RST_INDEX     8'h00
`define NVM_RST_FLAG      1'b0
`define NVM_RST_ABORT     1'b0
`define NVM_KEY_FIRST     8'h55
`define NVM_KEY_SECOND    8'hAA

// ************************************************************
// timing
// ************************************************************
`define NVM_CLK_MHZ         100
`define NVM_UNLOCK_GAP_CYC  3
`define NVM_PWRUP_TIME_MS   72
`define NVM_PWRUP_CYCLES    (`NVM_PWRUP_TIME_MS * 1000 * `NVM_CLK_MHZ)
`define NVM_PROG_TIME_US    50
`define NVM_PROG_CYCLES     (`NVM_PROG_TIME_US * `NVM_CLK_MHZ)

`endif

// ### nvm_access_pkg.sv
// types for the data array access block
// assumes nothing beyond a SystemVerilog compiler
package nvm_access_pkg;

    // ************************************************************
    // unlock sequence detector states
    // ************************************************************
    typedef enum logic [2:0] {
        KEY_IDLE   = 3'b001,
        KEY_FIRST  = 3'b010,
        KEY_SECOND = 3'b100
    } key_state_e;

    // ************************************************************
    // program cycle states
    // ************************************************************
    typedef enum logic [1:0] {
        PROG_IDLE = 2'b01,
        PROG_BUSY = 2'b10
    } prog_state_e;

endpackage

// ### prog_cycle_timer.sv
// down counter timing one program cycle of the data array
// assumes start arrives only while idle and length is at least one
`timescale 1ns/10ps
`default_nettype none
module prog_cycle_timer (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // control
    input  wire logic        abort,
    input  wire logic        start,
    input  wire logic [15:0] length,
    // status
    output logic             busy,
    output logic             done
);

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        done_reg;
    logic        done_next;

    // ************************************************************
    // next count
    // ************************************************************
    always_comb begin
        count_next = count_reg;
        done_next  = 1'b0;
        if (abort) begin
            count_next = 16'h0000;
        end else if (start) begin
            count_next = length;
        end else if (count_reg != 16'h0000) begin
            count_next = count_reg - 16'h0001;
            done_next  = (count_reg == 16'h0001);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
            done_reg  <= 1'b0;
        end else if (clk_en) begin
            count_reg <= count_next;
            done_reg  <= done_next;
        end
    end

    assign busy = (count_reg != 16'h0000);
    assign done = done_reg;

endmodule
`default_nettype wire

// ### data_eeprom_access_monitor.sv
// port checks for the data array access block
// assumes hready is the looped-back hreadyout and clk_en stays high
`timescale 1ns/10ps
`default_nettype none
`include "nvm_access_map.svh"
module data_eeprom_access_monitor #(
    parameter logic [22:0] PWRUP_CYCLES = 23'h000014,
    parameter logic [15:0] PROG_CYCLES  = 16'h000A
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // warm reset and fuse
    input  wire logic        wdt_reset,
    input  wire logic        data_lock_fuse,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    // status
    input  wire logic        program_busy,
    input  wire logic        program_done_flag,
    input  wire logic        programmer_access_en
);
    // ************************************************************
    // helper counters and properties
    // ************************************************************
    logic        taken, sw_flag, flag_wr_reg, flag_wr_next;
    logic [15:0] busy_cnt_reg, busy_cnt_next;
    logic [22:0] up_cnt_reg, up_cnt_next;
    assign taken   = hsel && htrans[1] && hready;
    // a flag write commits at the end of its wait cycle
    assign sw_flag = flag_wr_reg && !hreadyout;
    always_comb begin
        flag_wr_next  = taken && hwrite && (haddr == {22'h0, `NVM_IDX_FLAG, 2'h0});
        busy_cnt_next = program_busy ? busy_cnt_reg + 16'h1 : 16'h0;
        up_cnt_next   = (up_cnt_reg < PWRUP_CYCLES) ? up_cnt_reg + 23'h1 : up_cnt_reg;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flag_wr_reg  <= 1'b0;
            busy_cnt_reg <= 16'h0;
            up_cnt_reg   <= 23'h0;
        end else begin
            flag_wr_reg  <= flag_wr_next;
            busy_cnt_reg <= busy_cnt_next;
            up_cnt_reg   <= up_cnt_next;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_prog_end;
        $fell(program_busy) && !$past(wdt_reset);
    endsequence
    sequence s_zero_read;
        taken && !hwrite && (haddr == {22'h0, `NVM_IDX_KEY, 2'h0} || haddr[31:10] != 22'h0);
    endsequence
    sequence s_zero_answer;
        !hreadyout ##1 (hreadyout && hrdata == 32'h0);
    endsequence
    // busy spans the count plus the registered end pulse
    AST_BUSY_LEN: assert property (s_prog_end |-> busy_cnt_reg == PROG_CYCLES + 16'h1)
        else $error("program cycle length wrong");
    AST_DONE_AT_END: assert property (s_prog_end |-> program_done_flag)
        else $error("done flag missing at cycle end");
    AST_DONE_HOLDS: assert property (program_done_flag && !sw_flag && !wdt_reset
        |=> program_done_flag)
        else $error("done flag dropped by hardware");
    AST_DONE_SRC: assert property ($rose(program_done_flag)
        |-> $fell(program_busy) || $past(sw_flag))
        else $error("done flag rose without a finished cycle");
    AST_PWRUP_BLOCK: assert property (up_cnt_reg < PWRUP_CYCLES |-> !program_busy)
        else $error("program cycle during power-up time");
    AST_KEY_READ_ZERO: assert property (s_zero_read |=> s_zero_answer)
        else $error("key port or hole read not zero");
    AST_WARM_ABORT: assert property (wdt_reset && program_busy |=> !program_busy)
        else $error("warm reset did not end the cycle");
    AST_FUSE_LOCK: assert property (!data_lock_fuse [*4] |-> !programmer_access_en)
        else $error("programmer access not locked");
    AST_FUSE_OPEN: assert property (data_lock_fuse [*4] |-> programmer_access_en)
        else $error("programmer access locked without fuse");
endmodule
`default_nettype wire

// ### core_bus_model.sv
// register bus master standing in for the processor core
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/10ps
`default_nettype none
module core_bus_model (
    // clock
    input  wire logic        clk_sys,
    // master side of the bus
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b1;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'hFFFFFFFF;
    end
    // single transfers, nothing slips between the keys
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk_sys iff hready);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk_sys iff hready);
        q = hrdata[7:0];
        // released data shows the inverse, never a stale copy
        hwdata <= {24'hFFFFFF, ~d};
    endtask
endmodule
`default_nettype wire

// ### data_eeprom_access_tb.sv
// self-checking bench for the data array access block
// assumes the core bus model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
`include "nvm_access_map.svh"
module data_eeprom_access_tb;
    // ************************************************************
    // bench
    // ************************************************************
    localparam logic [15:0] PROG   = 16'h000A;
    localparam logic [31:0] A_FLAG = {22'h0, `NVM_IDX_FLAG, 2'h0};
    localparam logic [31:0] A_BYTE = {22'h0, `NVM_IDX_BYTE, 2'h0};
    localparam logic [31:0] A_IDX  = {22'h0, `NVM_IDX_INDEX, 2'h0};
    localparam logic [31:0] A_CTL  = {22'h0, `NVM_IDX_CONTROL, 2'h0};
    localparam logic [31:0] A_KEY  = {22'h0, `NVM_IDX_KEY, 2'h0};
    logic        clk_sys = 1'b0, reset_n = 1'b0, wdt_reset = 1'b0, data_lock_fuse = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp, program_busy, program_done_flag, prot_en;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [31:0] seed = 32'hED8C;
    logic [7:0]  rd, last_a;
    int          fails = 0, n_compared = 0, cyc = 0;
    int          mem [128];
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    data_eeprom_access #(.PWRUP_CYCLES(23'h00003C), .PROG_CYCLES(PROG)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .pin_reset_n(1'b1),
        .wdt_reset(wdt_reset), .data_lock_fuse(data_lock_fuse), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .program_busy(program_busy),
        .program_done_flag(program_done_flag), .programmer_access_en(prot_en));
    core_bus_model cpu (
        .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, a, d, rd);
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a, input logic [7:0] exp);
        cpu.xfer(1'b0, a, 8'h00, rd);
        check(what, rd, exp);
        check("response", {7'h0, hresp}, 8'h00);
    endtask
    // mode 1 leaves a gap in the unlock, mode 2 sends a wrong second key
    task automatic store(input logic [7:0] a, input logic [7:0] d, input logic arm,
                         input int mode);
        wr(A_IDX, a);
        wr(A_BYTE, d);
        wr(A_CTL, {5'h0, arm, 2'h0});
        // keys and start back to back in modes 0 and 2
        wr(A_KEY, `NVM_KEY_FIRST);
        if (mode == 1) @(posedge clk_sys);
        wr(A_KEY, (mode == 2) ? 8'hA5 : `NVM_KEY_SECOND);
        wr(A_CTL, {5'h0, arm, 2'h2});
    endtask
    task automatic fetch_chk(input logic [7:0] a);
        wr(A_IDX, a);
        wr(A_CTL, 8'h01);
        rd_chk("fetched byte", A_BYTE, 8'(mem[a[6:0]]));
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk("control", A_CTL, 8'h00);
        rd_chk("flags", A_FLAG, 8'h00);
        rd_chk("key port", A_KEY, 8'h00);
        cpu.xfer(1'b0, 32'h400, 8'h00, rd);
        store(8'h05, 8'h3C, 1'b1, 0);
        rd_chk("control", A_CTL, 8'h04);
        repeat (60) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            data_lock_fuse <= (i != 2);
            seed = xorshift(seed);
            last_a = seed[7:0];
            store(last_a, seed[15:8], 1'b1, 0);
            mem[last_a[6:0]] = seed[15:8];
            wr(A_CTL, 8'h00);
            check("busy", {7'h0, program_busy}, 8'h01);
            repeat (PROG + 4) @(posedge clk_sys);
            rd_chk("control", A_CTL, 8'h00);
            rd_chk("flags", A_FLAG, 8'h80);
            wr(A_FLAG, 8'h00);
            rd_chk("flags", A_FLAG, 8'h00);
            fetch_chk(last_a ^ 8'h80);
            check("lock", {7'h0, prot_en}, {7'h0, data_lock_fuse});
        end
        for (int m = 0; m < 3; m++) begin
            store(last_a, 8'hC3, m != 0, m);
            repeat (PROG + 4) @(posedge clk_sys);
            check("busy", {7'h0, program_busy}, 8'h00);
            fetch_chk(last_a);
        end
        store(last_a, 8'hC3, 1'b1, 0);
        wdt_reset <= 1'b1;
        @(posedge clk_sys);
        wdt_reset <= 1'b0;
        rd_chk("control", A_CTL, 8'h08);
        rd_chk("index", A_IDX, 8'h00);
        fetch_chk(last_a);
        print_verdict();
    end
endmodule
bind data_eeprom_access data_eeprom_access_monitor #(
    .PWRUP_CYCLES(PWRUP_CYCLES), .PROG_CYCLES(PROG_CYCLES)) mon (
    .clk_sys(clk_sys), .reset_n(reset_n), .wdt_reset(wdt_reset),
    .data_lock_fuse(data_lock_fuse), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .program_busy(program_busy), .program_done_flag(program_done_flag),
    .programmer_access_en(programmer_access_en));
`default_nettype wire
